// File: hdl/ebt_pkg.sv
package ebt_pkg;

   // Register byte offsets
   localparam logic [7:0] EBT_CTRL_OFS    = 8'h00;
   localparam logic [7:0] EBT_STATUS_OFS  = 8'h04;
   localparam logic [7:0] EBT_MASK_OFS    = 8'h08;
   localparam logic [7:0] EBT_BRKPC_OFS   = 8'h0C;
   localparam logic [7:0] EBT_DISP_OFS    = 8'h10;
   localparam logic [7:0] EBT_DISASSEMBLE_COMMAND_OFS    = 8'h14;
   localparam logic [7:0] EBT_CNTB_OFS    = 8'h18;

   // Control register field positions
   localparam int EBT_CTRL_USER_RESET_ENABLE_COMMAND_EN_POS  = 0;
   localparam int EBT_CTRL_CLKSRC_POS   = 1;
   localparam int EBT_CTRL_RUNSTOP_POS  = 3;
   localparam int EBT_CTRL_LCDPORT_POS  = 4;
   localparam int EBT_CTRL_EMURUN_POS   = 5;

   // Status and mask bit positions
   localparam int EBT_ST_BRK_POS     = 0;
   localparam int EBT_ST_DISCARD_POS = 1;
   localparam int EBT_ST_USER_RESET_ENABLE_COMMAND_POS    = 2;

   // Reset values
   localparam logic [5:0] EBT_CTRL_RST   = 6'h00;
   localparam logic [2:0] EBT_STATUS_RST = 3'h0;
   localparam logic [2:0] EBT_MASK_RST   = 3'h0;
   localparam logic [7:0] EBT_DISP_RST   = 8'h00;

   // Shared opcodes and disassembly answer codes
   localparam logic [7:0] EBT_OP_NOP     = 8'h00;
   localparam logic [7:0] EBT_OP_INA     = 8'h01;
   localparam logic [7:0] EBT_OP_LAM     = 8'h70;
   localparam logic [7:0] EBT_OP_XAM     = 8'h71;
   localparam logic [2:0] EBT_DISASSEMBLE_COMMAND_NOP   = 3'h1;
   localparam logic [2:0] EBT_DISASSEMBLE_COMMAND_INA   = 3'h2;
   localparam logic [2:0] EBT_DISASSEMBLE_COMMAND_LAM   = 3'h3;
   localparam logic [2:0] EBT_DISASSEMBLE_COMMAND_XAM   = 3'h4;
   localparam logic [2:0] EBT_DISASSEMBLE_COMMAND_OTHER = 3'h0;

   // CR oscillator stand-in: half period of the pod clock
   localparam real EBT_CLK_MHZ       = 40.0;
   localparam real EBT_CR_HALF_NS    = 500.0;
   localparam int  EBT_CR_HALF_CYC   = (EBT_CR_HALF_NS * EBT_CLK_MHZ / 1000.0 < 1.0) ? 1 :
                                       int'(EBT_CR_HALF_NS * EBT_CLK_MHZ / 1000.0);

   typedef enum logic [1:0] {
      EBT_CLK_INTERNAL,
      EBT_CLK_EXT_LOW,
      EBT_CLK_EXT_HIGH,
      EBT_CLK_RESERVED
   } ebt_clksrc_e;

   typedef struct packed {
      logic        instr_bound;
      logic        exec;
      logic [7:0]  opcode;
      logic        skip_active;
      logic        target_skipped;
      logic        int_xfer;
      logic        halt_mode;
      logic        step;
      logic [12:0] pc;
      logic [12:0] vector;
   } ebt_core_s;

   typedef struct packed {
      logic cond;
      logic addr_type;
   } ebt_brk_s;

endpackage

// File: hdl/ebt_break_port.sv
// Overview of operation
// - Break seen during a skip is held and taken after the skip, also when stepping.
// - Address break whose instruction is skipped is dropped; other break types are held.
// - Break during interrupt transfer waits; captured PC is the vector.
// - Add-immediate-skip right after a carry add/subtract skip has its skip suppressed.
// - After a break or single step, that suppression is not applied.
// - Disassembly of shared opcodes answers with the first instruction name.
// - Pod CR clock supplied unless conversion run/stop select is one.
// - Counter B keeps counting whether emulation runs or stops.
// - Time base at break is not repeatable across the two clocks.
// - Halt monitor pin is high exactly in halt mode.
// - Enabled user reset pin low during emulation resets the board.
// - Low-speed clock pin used only when external low option is chosen.
// - High-speed clock pin used only when external high option is chosen.
// - In port mode, port 5 shows display reg zero, port 6 display reg one.
// - User reset leaves the display registers untouched.
module ebt_break_port
   import ebt_pkg::*;
#(
   parameter logic [7:0] AIS_BASE       = 8'h00,
   parameter logic [7:0] AIS_MASK       = 8'hF0,
   parameter logic [7:0] ADD_CS_OP      = 8'h10,
   parameter logic [7:0] ADD_CS_IND_OP  = 8'h11,
   parameter logic [7:0] SUB_CS_OP      = 8'h12,
   parameter logic [7:0] SUB_CS_IND_OP  = 8'h13
)(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire ebt_core_s   core_i,
   input  wire ebt_brk_s    brk_i,
   input  wire logic        user_reset_b_pin_i,
   input  wire logic        low_speed_clock_pin_i,
   input  wire logic        high_speed_clock_pin_i,
   output logic             halt_to_monitor_o,
   output logic [12:0]      break_pc_o,
   output logic             skip_suppress_o,
   output logic             halt_mon_o,
   output logic             board_reset_o,
   output logic             low_clk_o,
   output logic             high_clk_o,
   output logic             adc_clk_o,
   output logic [3:0]       port5_o,
   output logic [3:0]       port6_o,
   output logic             irq_o
);

   function automatic logic [2:0] disassemble_command_code(input logic [7:0] op);
      case (op)
         EBT_OP_NOP: disassemble_command_code = EBT_DISASSEMBLE_COMMAND_NOP;
         EBT_OP_INA: disassemble_command_code = EBT_DISASSEMBLE_COMMAND_INA;
         EBT_OP_LAM: disassemble_command_code = EBT_DISASSEMBLE_COMMAND_LAM;
         EBT_OP_XAM: disassemble_command_code = EBT_DISASSEMBLE_COMMAND_XAM;
         default:    disassemble_command_code = EBT_DISASSEMBLE_COMMAND_OTHER;
      endcase
   endfunction

   function automatic logic is_carry_skip(input logic [7:0] op);
      is_carry_skip = (op == ADD_CS_OP) || (op == ADD_CS_IND_OP) ||
                      (op == SUB_CS_OP) || (op == SUB_CS_IND_OP);
   endfunction

   typedef enum logic [1:0] {EBT_IDLE, EBT_PEND, EBT_HALTED} ebt_brk_state_e;

   // Pin synchronisers
   logic [2:0] sync1;
   logic [2:0] sync2;
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sync1 <= 3'h7;
         sync2 <= 3'h7;
      end
      else
      begin
         sync1 <= {high_speed_clock_pin_i, low_speed_clock_pin_i, user_reset_b_pin_i};
         sync2 <= sync1;
      end
   end
   logic user_reset_enable_command_b_s;
   logic xt_s;
   logic osc_s;
   assign user_reset_enable_command_b_s = sync2[0];
   assign xt_s     = sync2[1];
   assign osc_s    = sync2[2];

   // Registers
   logic [5:0]     ctrl;
   logic [2:0]     status;
   logic [2:0]     mask;
   logic [7:0]     disp;
   logic [2:0]     disassemble_command;
   logic [3:0]     cntb;
   logic [15:0]    cr_cnt;
   ebt_brk_state_e state;
   logic           pend_drop_ok;
   logic           pend_int;
   logic           prev_cs;
   logic [5:0]     next_ctrl;
   logic [2:0]     next_status;
   logic [2:0]     next_mask;
   logic [7:0]     next_disp;
   logic [2:0]     next_disassemble_command;
   logic [3:0]     next_cntb;
   logic [15:0]    next_cr_cnt;
   ebt_brk_state_e next_state;
   logic           next_pend_drop_ok;
   logic           next_pend_int;
   logic           next_prev_cs;
   logic [31:0]    next_rdata;
   logic           next_halt;
   logic [12:0]    next_break_pc;
   logic           next_suppress;
   logic           next_board_reset;
   logic           next_low_clk;
   logic           next_high_clk;
   logic           next_adc_clk;
   logic [3:0]     next_port5;
   logic [3:0]     next_port6;
   logic [2:0]     ev;
   ebt_clksrc_e    clksrc;
   logic           take_ok;
   logic           drop;

   assign clksrc = ebt_clksrc_e'(ctrl[EBT_CTRL_CLKSRC_POS +: 2]);

   always_comb
   begin
      next_ctrl         = ctrl;
      next_mask         = mask;
      next_disp         = disp;
      next_disassemble_command         = disassemble_command;
      next_state        = state;
      next_pend_drop_ok = pend_drop_ok;
      next_pend_int     = pend_int;
      next_prev_cs      = prev_cs;
      next_halt         = 1'b0;
      next_break_pc     = break_pc_o;
      next_suppress     = 1'b0;
      next_rdata        = 32'h0000_0000;
      ev                = 3'h0;
      // Boundary free of skip and interrupt transfer
      take_ok = core_i.instr_bound && !core_i.skip_active && !core_i.int_xfer;
      drop    = pend_drop_ok && core_i.target_skipped;

      case (state)
         EBT_IDLE:
         begin
            if (brk_i.cond)
            begin
               if (brk_i.addr_type && core_i.target_skipped)
                  ev[EBT_ST_DISCARD_POS] = 1'b1;
               else if (take_ok)
               begin
                  next_halt     = 1'b1;
                  next_break_pc = core_i.pc;
                  next_state    = EBT_HALTED;
                  ev[EBT_ST_BRK_POS] = 1'b1;
               end
               else
               begin
                  next_state        = EBT_PEND;
                  next_pend_drop_ok = brk_i.addr_type;
                  next_pend_int     = core_i.int_xfer;
               end
            end
         end
         EBT_PEND:
         begin
            if (drop)
            begin
               next_state = EBT_IDLE;
               ev[EBT_ST_DISCARD_POS] = 1'b1;
            end
            else if (take_ok)
            begin
               next_halt     = 1'b1;
               next_break_pc = pend_int ? core_i.vector : core_i.pc;
               next_state    = EBT_HALTED;
               ev[EBT_ST_BRK_POS] = 1'b1;
            end
            else if (core_i.int_xfer)
               next_pend_int = 1'b1;
         end
         EBT_HALTED:
         begin
            // Leaves once the core runs again and the break condition is low
            if (!core_i.halt_mode && !brk_i.cond)
               next_state = EBT_IDLE;
         end
         default:
            next_state = EBT_IDLE;
      endcase

      // Carry-skip history; a break or step forgets it
      if (next_halt || core_i.step)
         next_prev_cs = 1'b0;
      else if (core_i.exec)
      begin
         next_suppress = prev_cs && ((core_i.opcode & AIS_MASK) == AIS_BASE);
         next_prev_cs  = is_carry_skip(core_i.opcode);
      end

      if (!board_reset_o && user_reset_enable_command_b_s == 1'b0 && ctrl[EBT_CTRL_USER_RESET_ENABLE_COMMAND_EN_POS] &&
          ctrl[EBT_CTRL_EMURUN_POS])
         ev[EBT_ST_USER_RESET_ENABLE_COMMAND_POS] = 1'b1;

      // Hardware set wins over a same-cycle clear
      next_status = status;
      if (wr_i && addr_i == EBT_STATUS_OFS)
         next_status = status & ~wdata_i[2:0];
      next_status = next_status | ev;

      if (wr_i)
      begin
         case (addr_i)
            EBT_CTRL_OFS: next_ctrl = wdata_i[5:0];
            EBT_MASK_OFS: next_mask = wdata_i[2:0];
            EBT_DISP_OFS: next_disp = wdata_i[7:0];
            EBT_DISASSEMBLE_COMMAND_OFS: next_disassemble_command = disassemble_command_code(wdata_i[7:0]);
            default:      next_disassemble_command = disassemble_command;
         endcase
      end
      if (rd_i)
      begin
         case (addr_i)
            EBT_CTRL_OFS:   next_rdata = {26'h0, ctrl};
            EBT_STATUS_OFS: next_rdata = {29'h0, status};
            EBT_MASK_OFS:   next_rdata = {29'h0, mask};
            EBT_BRKPC_OFS:  next_rdata = {19'h0, break_pc_o};
            EBT_DISP_OFS:   next_rdata = {24'h0, disp};
            EBT_DISASSEMBLE_COMMAND_OFS:   next_rdata = {29'h0, disassemble_command};
            EBT_CNTB_OFS:   next_rdata = {28'h0, cntb};
            default:        next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Pod clock and counter B: independent of the run state
   always_comb
   begin
      next_cr_cnt  = cr_cnt;
      next_adc_clk = adc_clk_o;
      next_cntb    = cntb;
      if (ctrl[EBT_CTRL_RUNSTOP_POS])
      begin
         next_adc_clk = 1'b0;
         next_cr_cnt  = 16'h0000;
      end
      else if (cr_cnt == 16'(EBT_CR_HALF_CYC - 1))
      begin
         next_cr_cnt  = 16'h0000;
         next_adc_clk = !adc_clk_o;
         if (adc_clk_o)
            next_cntb = cntb + 4'h1;
      end
      else
         next_cr_cnt = cr_cnt + 16'h0001;
   end

   // Pins; sampled clocks are only as good as two-flop jitter allows
   always_comb
   begin
      next_board_reset = ctrl[EBT_CTRL_USER_RESET_ENABLE_COMMAND_EN_POS] && ctrl[EBT_CTRL_EMURUN_POS] &&
                         !user_reset_enable_command_b_s;
      next_low_clk  = (clksrc == EBT_CLK_EXT_LOW)  ? xt_s  : 1'b0;
      next_high_clk = (clksrc == EBT_CLK_EXT_HIGH) ? osc_s : 1'b0;
      next_port5    = ctrl[EBT_CTRL_LCDPORT_POS] ? disp[3:0] : 4'h0;
      next_port6    = ctrl[EBT_CTRL_LCDPORT_POS] ? disp[7:4] : 4'h0;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ctrl              <= EBT_CTRL_RST;
         status            <= EBT_STATUS_RST;
         mask              <= EBT_MASK_RST;
         disp              <= EBT_DISP_RST;
         disassemble_command              <= EBT_DISASSEMBLE_COMMAND_OTHER;
         cntb              <= 4'h0;
         cr_cnt            <= 16'h0000;
         state             <= EBT_IDLE;
         pend_drop_ok      <= 1'b0;
         pend_int          <= 1'b0;
         prev_cs           <= 1'b0;
         rdata_o           <= 32'h0000_0000;
         halt_to_monitor_o <= 1'b0;
         break_pc_o        <= 13'h0000;
         skip_suppress_o   <= 1'b0;
         halt_mon_o        <= 1'b0;
         board_reset_o     <= 1'b0;
         low_clk_o         <= 1'b0;
         high_clk_o        <= 1'b0;
         adc_clk_o         <= 1'b0;
         port5_o           <= 4'h0;
         port6_o           <= 4'h0;
         irq_o             <= 1'b0;
      end
      else
      begin
         ctrl              <= next_ctrl;
         status            <= next_status;
         mask              <= next_mask;
         // Board reset does not touch disp
         disp              <= next_disp;
         disassemble_command              <= next_disassemble_command;
         cntb              <= next_cntb;
         cr_cnt            <= next_cr_cnt;
         state             <= next_state;
         pend_drop_ok      <= next_pend_drop_ok;
         pend_int          <= next_pend_int;
         prev_cs           <= next_prev_cs;
         rdata_o           <= next_rdata;
         halt_to_monitor_o <= next_halt;
         break_pc_o        <= next_break_pc;
         skip_suppress_o   <= next_suppress;
         halt_mon_o        <= core_i.halt_mode;
         board_reset_o     <= next_board_reset;
         low_clk_o         <= next_low_clk;
         high_clk_o        <= next_high_clk;
         adc_clk_o         <= next_adc_clk;
         port5_o           <= next_port5;
         port6_o           <= next_port6;
         irq_o             <= |(next_status & next_mask);
      end
   end

   brk_in_skip_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      core_i.skip_active |=> !halt_to_monitor_o)
      else $error("break taken during a skip");

   skip_drop_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (state == EBT_PEND && pend_drop_ok && core_i.target_skipped)
      |=> state == EBT_IDLE && status[EBT_ST_DISCARD_POS] && !halt_to_monitor_o)
      else $error("skipped address break not discarded");

   int_vector_pc_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (state == EBT_PEND && pend_int && !drop && take_ok)
      |=> halt_to_monitor_o && break_pc_o == $past(core_i.vector))
      else $error("break pc is not the vector");

   ais_suppress_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (core_i.exec && prev_cs && !core_i.step && !next_halt &&
       (core_i.opcode & AIS_MASK) == AIS_BASE) |=> skip_suppress_o)
      else $error("skip not suppressed after carry skip");

   step_nosupp_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      core_i.step ##1 (core_i.exec && !core_i.step) |=> !skip_suppress_o)
      else $error("suppression kept over a step");

   disassemble_command_share_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_i && addr_i == EBT_DISASSEMBLE_COMMAND_OFS && wdata_i[7:0] == EBT_OP_LAM)
      |=> disassemble_command == EBT_DISASSEMBLE_COMMAND_LAM)
      else $error("shared opcode decoded wrong");

   pod_clk_stop_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      ctrl[EBT_CTRL_RUNSTOP_POS] |=> !adc_clk_o)
      else $error("pod clock runs while stopped");

   cntb_run_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (!ctrl[EBT_CTRL_RUNSTOP_POS] && adc_clk_o && !next_adc_clk)
      |=> cntb == $past(cntb) + 4'h1)
      else $error("counter b stalled");

   halt_mon_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      ##1 halt_mon_o == $past(core_i.halt_mode))
      else $error("halt monitor wrong");

   user_reset_enable_command_gate_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      !ctrl[EBT_CTRL_USER_RESET_ENABLE_COMMAND_EN_POS] |=> !board_reset_o)
      else $error("user reset while disabled");

   clk_gate_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (clksrc != EBT_CLK_EXT_LOW) |=> !low_clk_o)
      else $error("low clock passed while not selected");

   port_map_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      ctrl[EBT_CTRL_LCDPORT_POS] |=> port6_o == $past(disp[7:4]))
      else $error("port 6 not display reg one");

   disp_keep_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (board_reset_o && !(wr_i && addr_i == EBT_DISP_OFS)) |=> $stable(disp))
      else $error("display regs lost on user reset");

   take_boundary_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(halt_to_monitor_o) |-> $past(core_i.instr_bound && !core_i.int_xfer))
      else $error("halt off an instruction boundary");

endmodule

// File: verification/ebt_target_model.sv
module ebt_target_model (
   input  wire logic press_i,
   output logic      user_reset_b_o,
   output logic      low_clk_o,
   output logic      high_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Target crystals run free, unrelated in phase to the core clock
   initial low_clk_o = 1'b0;
   initial high_clk_o = 1'b0;
   always #300 low_clk_o = ~low_clk_o;
   always #90 high_clk_o = ~high_clk_o;
   // Pulled up on the target, so a released button reads high
   assign user_reset_b_o = ~press_i;
endmodule

// File: verification/tb_top.sv
module tb_top
   import ebt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        rst_b;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   ebt_core_s   core;
   ebt_brk_s    brk;
   logic        press;
   logic        ureset_b;
   logic        lo_pin;
   logic        hi_pin;
   logic        halt_tm;
   logic [12:0] brk_pc;
   logic        supp;
   logic        halt_mon;
   logic        brd_rst;
   logic        lo_clk;
   logic        hi_clk;
   logic        adc_clk;
   logic [3:0]  p5;
   logic [3:0]  p6;
   logic        irq;
   logic [5:0]  mon;
   logic [5:0]  mon_q;
   logic [31:0] c0;
   logic [31:0] c1;
   int          n_mismatch;
   int          checked;
   int          cycles;
   int          b;
   int          rises [6];
   logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1C};
   logic [7:0]  dop [5] = '{EBT_OP_NOP, EBT_OP_INA, EBT_OP_LAM, EBT_OP_XAM, 8'h42};
   logic [2:0]  dcd [5] = '{EBT_DISASSEMBLE_COMMAND_NOP, EBT_DISASSEMBLE_COMMAND_INA, EBT_DISASSEMBLE_COMMAND_LAM, EBT_DISASSEMBLE_COMMAND_XAM, 3'h0};
   logic [7:0]  cs_op [4] = '{8'h10, 8'h11, 8'h12, 8'h13};

   ebt_break_port dut (
      .ref_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .core_i(core), .brk_i(brk),
      .user_reset_b_pin_i(ureset_b), .low_speed_clock_pin_i(lo_pin),
      .high_speed_clock_pin_i(hi_pin), .halt_to_monitor_o(halt_tm), .break_pc_o(brk_pc),
      .skip_suppress_o(supp), .halt_mon_o(halt_mon), .board_reset_o(brd_rst),
      .low_clk_o(lo_clk), .high_clk_o(hi_clk), .adc_clk_o(adc_clk), .port5_o(p5),
      .port6_o(p6), .irq_o(irq));
   ebt_target_model target (.press_i(press), .user_reset_b_o(ureset_b),
      .low_clk_o(lo_pin), .high_clk_o(hi_pin));

   always #12.5 clk = ~clk;
   assign mon = {brd_rst, adc_clk, hi_clk, lo_clk, halt_tm, supp};
   // Rising edges counted, so one-cycle pulses are never missed between checks
   always @(posedge clk)
   begin
      mon_q <= mon;
      for (int i = 0; i < 6; i++)
         if (mon[i] === 1'b1 && mon_q[i] === 1'b0) rises[i] <= rises[i] + 1;
      cycles <= cycles + 1;
      if (cycles == 12000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   task give_verdict();
      if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task chk_rng(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi)
      begin
         n_mismatch++;
         $display("MISMATCH %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_get(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd_get(a, d);
      chk(d, exp);
   endtask
   task brk_pulse(input logic at);
      @(posedge clk);
      brk.cond <= 1'b1;
      brk.addr_type <= at;
      @(posedge clk);
      brk.cond <= 1'b0;
   endtask
   task exec_op(input logic [7:0] op);
      @(posedge clk);
      core.exec <= 1'b1;
      core.opcode <= op;
      @(posedge clk);
      core.exec <= 1'b0;
   endtask

   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      {addr, wdata, wr, rd, press, brk, mon_q} = '0;
      core = '0;
      core.instr_bound = 1'b1;
      {n_mismatch, checked, cycles} = '0;
      foreach (rises[i]) rises[i] = 0;
      cyc(10);
      rst_b <= 1'b1;
      cyc(2);
      foreach (ofs[i]) rd_chk(ofs[i], 32'h0);
      foreach (dop[i])
      begin
         wr_reg(EBT_DISASSEMBLE_COMMAND_OFS, {24'h0, dop[i]});
         rd_chk(EBT_DISASSEMBLE_COMMAND_OFS, {29'h0, dcd[i]});
      end
      wr_reg(EBT_DISP_OFS, 32'hA5);
      cyc(2);
      chk({p6, p5}, 8'h00);
      wr_reg(EBT_CTRL_OFS, 32'h10);
      cyc(2);
      chk({p6, p5}, 8'hA5);
      // Break held through a skip
      b = rises[1];
      @(posedge clk) {core.skip_active, core.pc} <= {1'b1, 13'h0ABC};
      brk_pulse(1'b0);
      cyc(4);
      chk_rng(rises[1] - b, 0, 0);
      @(posedge clk) core.skip_active <= 1'b0;
      cyc(3);
      chk_rng(rises[1] - b, 1, 1);
      chk(brk_pc, 13'h0ABC);
      @(posedge clk) core.halt_mode <= 1'b1;
      cyc(2);
      chk(halt_mon, 1'b1);
      @(posedge clk) core.halt_mode <= 1'b0;
      cyc(2);
      chk(halt_mon, 1'b0);
      rd_chk(EBT_STATUS_OFS, 32'h1);
      // Skipped target seen at the request, then only while pending
      for (int k = 0; k < 2; k++)
      begin
         wr_reg(EBT_STATUS_OFS, 32'h3);
         b = rises[1];
         @(posedge clk) {core.skip_active, core.target_skipped} <= {1'b1, k == 0};
         brk_pulse(1'b1);
         @(posedge clk) core.target_skipped <= 1'b1;
         cyc(1);
         @(posedge clk) {core.skip_active, core.target_skipped} <= 2'b00;
         cyc(4);
         chk_rng(rises[1] - b, 0, 0);
         rd_chk(EBT_STATUS_OFS, 32'h2);
      end
      chk(irq, 1'b0);
      wr_reg(EBT_MASK_OFS, 32'h2);
      cyc(2);
      chk(irq, 1'b1);
      wr_reg(EBT_STATUS_OFS, 32'h2);
      cyc(2);
      chk(irq, 1'b0);
      // Break during an interrupt transfer lands on the vector
      b = rises[1];
      @(posedge clk) {core.int_xfer, core.vector, core.pc} <= {1'b1, 13'h1F40, 13'h0123};
      brk_pulse(1'b0);
      cyc(4);
      chk_rng(rises[1] - b, 0, 0);
      @(posedge clk) core.int_xfer <= 1'b0;
      cyc(3);
      chk_rng(rises[1] - b, 1, 1);
      rd_chk(EBT_BRKPC_OFS, 32'h1F40);
      wr_reg(EBT_STATUS_OFS, 32'h1);
      foreach (cs_op[i])
      begin
         b = rises[0];
         exec_op(cs_op[i]);
         exec_op(8'h05);
         cyc(2);
         chk_rng(rises[0] - b, 1, 1);
      end
      // Add-immediate-skip executes in the cycle right after the step
      b = rises[0];
      exec_op(8'h10);
      @(posedge clk) core.step <= 1'b1;
      @(posedge clk) {core.step, core.exec, core.opcode} <= {1'b0, 1'b1, 8'h05};
      @(posedge clk) core.exec <= 1'b0;
      exec_op(8'h12);
      brk_pulse(1'b0);
      cyc(3);
      @(posedge clk) core.halt_mode <= 1'b1;
      @(posedge clk) core.halt_mode <= 1'b0;
      exec_op(8'h05);
      cyc(2);
      chk_rng(rises[0] - b, 0, 0);
      // Break just taken left its status bit set
      wr_reg(EBT_STATUS_OFS, 32'h1);
      // Pod clock and counter B, emulation stopped then running
      for (int e = 0; e < 2; e++)
      begin
         wr_reg(EBT_CTRL_OFS, 32'h10 | (e << 5));
         rd_get(EBT_CNTB_OFS, c0);
         b = rises[4];
         cyc(200);
         chk_rng(rises[4] - b, 4, 6);
         rd_get(EBT_CNTB_OFS, c1);
         chk_rng(int'((c1 - c0) & 32'hF), 4, 6);
      end
      wr_reg(EBT_CTRL_OFS, 32'h18);
      cyc(25);
      b = rises[4];
      cyc(100);
      chk_rng(rises[4] - b, 0, 0);
      chk(adc_clk, 1'b0);
      // Pin clocks only counted in ranges: sampling jitter makes exact counts vary
      for (int s = 0; s < 3; s++)
      begin
         wr_reg(EBT_CTRL_OFS, s << 1);
         cyc(6);
         b = rises[2];
         c0 = rises[3];
         cyc(100);
         chk_rng(rises[2] - b, (s == 1) ? 3 : 0, (s == 1) ? 5 : 0);
         chk_rng(rises[3] - int'(c0), (s == 2) ? 12 : 0, (s == 2) ? 15 : 0);
      end
      for (int u = 0; u < 2; u++)
      begin
         wr_reg(EBT_CTRL_OFS, 32'h20 | u);
         b = rises[5];
         @(posedge clk) press <= 1'b1;
         cyc(10);
         @(posedge clk) press <= 1'b0;
         cyc(5);
         chk_rng(rises[5] - b, u, u);
      end
      rd_chk(EBT_STATUS_OFS, 32'h4);
      rd_chk(EBT_DISP_OFS, 32'hA5);
      give_verdict();
   end
endmodule
